/* hwsmb_host.sv */
/* hwsmb_host: host bus controller model with start, stop, byte write and byte read tasks.
   assumes a pull-up on sda; scl stands high between frames and is never stretched. */
`timescale 1ns/1ps
module hwsmb_host (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    localparam time Q = 200; // quarter bit, keeps scl low time at 400 ns
    // bus idles released
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one bit: data moves only while scl is low, sampled mid-high
    task automatic bit_c(input logic b, output logic r);
        sda_low = ~b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
        #Q;
    endtask : bit_c
    // start or repeated start: sda falls while scl is high
    task automatic start_c;
        sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask : start_c
    // stop: sda rises while scl is high
    task automatic stop_c;
        sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask : stop_c
    // eight bits out, then the device's acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_c(d[i], r);
        bit_c(1'b1, r);
        ack = ~r;
    endtask : wbyte
    // eight bits in, then the host's acknowledge or refusal
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_c(1'b1, r);
            d[i] = r;
        end
        bit_c(nack, r);
    endtask : rbyte
endmodule : hwsmb_host

/* hwsmb_pkg.sv */
/*
 * hwsmb_pkg: constants, types and helpers shared by the monitor's SMBus target port.
 * Assumes a 50 MHz reference clock; the register map itself lives outside the port.
 */
package hwsmb_pkg;

    // target address: six fixed upper bits, low bit taken from the strap
    localparam logic [5:0] TGT_ADDR_HI     = 6'h16;
    localparam logic [6:0] GEN_CALL_ADDR   = 7'h00;
    // span of register offsets treated as live registers
    localparam logic [7:0] REG_VALID_LO    = 8'h20;
    localparam logic [7:0] REG_VALID_HI    = 8'h7F;
    // reset values, and the bit count of one byte
    localparam logic [7:0] PTR_RST         = 8'h00;
    localparam logic [7:0] BYTE_RST        = 8'h00;
    localparam logic [3:0] CNT_RST         = 4'h0;
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
    // reset pulse timing on the shared pin
    localparam int         REF_CLK_HZ      = 50_000_000;
    localparam int         RST_PULSE_MS    = 20;
    localparam int         RST_PULSE_CYC   = RST_PULSE_MS * (REF_CLK_HZ / 1000);

    // function of the shared address/alert pin after power-up
    typedef enum logic [1:0] {
        PIN_ADDR_ONLY,
        PIN_RESET_OUT,
        PIN_ALERT_OUT,
        PIN_CHAIN_OUT
    } hwsmb_pin_mode_t;

    // link-side protocol states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_REG,
        ST_REG_ACK,
        ST_DATA,
        ST_DATA_ACK,
        ST_HOLD,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } hwsmb_state_t;

    // one register write handed to the register map
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } hwsmb_wr_t;

    // true when the seven received address bits name this port
    function automatic logic hwsmb_addr_hit(input logic [6:0] rx, input logic strap);
        hwsmb_addr_hit = (rx == {TGT_ADDR_HI, strap}) && (rx != GEN_CALL_ADDR);
    endfunction : hwsmb_addr_hit

    // true for an offset inside the live register span
    function automatic logic hwsmb_reg_ok(input logic [7:0] a);
        hwsmb_reg_ok = (a >= REG_VALID_LO) && (a <= REG_VALID_HI);
    endfunction : hwsmb_reg_ok

endpackage : hwsmb_pkg

/* hwsmb_sync.sv */
/*
 * hwsmb_sync: two-flop level synchroniser, one bit per lane.
 * Assumes each lane is a level or a slow toggle from another clock domain.
 */
`timescale 1ns/1ps
module hwsmb_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        meta_ff <= d;
        q       <= meta_ff;
    end
endmodule : hwsmb_sync

/* hwsmb_target.sv */
/*
 * hwsmb_target: SMBus target port of the hardware monitor, plus shared address pin.
 * Assumes the register map answers reg_rd_data in the cycle of reg_rd_pulse, and that
 * link_clk runs free and much faster than the bus clock so that lines can be oversampled.
 */
`timescale 1ns/1ps
// Summary of operation
// - target only; four byte protocols accepted
// - answer address 010110 plus strap bit
// - pulled-up shared pin straps address 0101101
// - seven-bit address, register byte, data byte
// - all bytes shifted most significant first
// - write: address, pointer byte, one data
// - write byte order with device acknowledges
// - register written only after complete write
// - read: pointer write, restart, read one byte
// - bare read returns pointed register unchanged
// - pointer byte selects register for data
// - only live register offsets are accepted
// - supply input optionally read as id bit
// - shared pin: reset pulse, alert, chain
// - bad address/register/protocol: silent, idle
// - send byte loads pointer only
// - start then stop resets to idle
// - ignore general call; never stretch clock
module hwsmb_target #(
    parameter int RST_PULSE_CYCLES = hwsmb_pkg::RST_PULSE_CYC
) (
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    input  wire logic                      link_clk,
    input  wire logic                      scl_i,
    input  wire logic                      sda_i,
    output logic                           sda_o,
    output logic                           sda_oe,
    input  wire logic                      shared_addr_alert_pin_i,
    output logic                           shared_addr_alert_pin_o,
    output logic                           shared_addr_alert_pin_oe,
    input  wire hwsmb_pkg::hwsmb_pin_mode_t pin_mode,
    input  wire logic                      reset_pulse_start,
    input  wire logic                      limit_alert_out,
    input  wire logic                      diode0_neg_or_chain_in,
    input  wire logic                      processor_voltage_id_bit4_select,
    input  wire logic                      supply12_or_vid_bit4,
    output logic                           processor_voltage_id_bit4,
    output logic                           reg_wr_pulse,
    output hwsmb_pkg::hwsmb_wr_t           reg_wr,
    output logic                           reg_rd_pulse,
    output logic                      [7:0] reg_rd_addr,
    input  wire logic                 [7:0] reg_rd_data
);
    // ---------------- link domain ----------------
    logic [4:0]              lk_sync;
    logic                    link_rst_n;
    logic                    scl_s;
    logic                    sda_s;
    logic                    pin_s;
    logic                    rd_ack_s;
    logic                    scl_d_ff;
    logic                    sda_d_ff;
    logic                    rd_ack_d_ff;
    logic                    scl_rise;
    logic                    scl_fall;
    logic                    start_det;
    logic                    stop_det;
    logic                    strap_ff;
    logic                    strap_taken_ff;
    hwsmb_pkg::hwsmb_state_t state_ff;
    logic [3:0]              cnt_ff;
    logic [7:0]              shift_ff;
    logic [7:0]              tx_ff;
    logic [7:0]              tx_buf_ff;
    logic [7:0]              ptr_ff;
    logic [7:0]              wdat_ff;
    logic                    rw_ff;
    logic                    oe_ff;
    logic                    wr_tgl_ff;
    logic                    rd_tgl_ff;
    // ---------------- reference domain ----------------
    logic [3:0]              rf_sync;
    logic                    wr_tgl_s;
    logic                    rd_tgl_s;
    logic                    chain_s;
    logic                    vid_s;
    logic                    wr_tgl_d_ff;
    logic                    rd_tgl_d_ff;
    logic                    rd_ack_tgl_ff;
    logic [7:0]              rd_hold_ff;
    logic                    wr_pulse_ff;
    logic                    rd_pulse_ff;
    hwsmb_pkg::hwsmb_wr_t    wr_ff;
    logic [7:0]              rd_addr_ff;
    logic [31:0]             pulse_cnt_ff;
    logic                    pin_oe_ff;
    logic                    vid_ff;

    // bus lines, strap pin, handshake return and reset brought onto link_clk
    hwsmb_sync #(.W(5)) u_link_sync (
        .clk (link_clk),
        .d   ({reset_n, scl_i, sda_i, shared_addr_alert_pin_i, rd_ack_tgl_ff}),
        .q   (lk_sync)
    );
    assign {link_rst_n, scl_s, sda_s, pin_s, rd_ack_s} = lk_sync;

    // line history for edge and condition detection
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            scl_d_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
            rd_ack_d_ff <= 1'b0;
        end
        else
        begin
            scl_d_ff    <= scl_s;
            sda_d_ff    <= sda_s;
            rd_ack_d_ff <= rd_ack_s;
        end
    end

    // start and stop are data edges while the clock stays high
    assign scl_rise  = scl_s & ~scl_d_ff;
    assign scl_fall  = ~scl_s & scl_d_ff;
    assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // address low bit caught once after reset; a pulled-up pin gives 1
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            strap_ff       <= 1'b0;
            strap_taken_ff <= 1'b0;
        end
        else if (!strap_taken_ff)
        begin
            strap_ff       <= pin_s;
            strap_taken_ff <= 1'b1;
        end
    end

    // read data returned from the register map, taken on the answer toggle
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
            tx_buf_ff <= hwsmb_pkg::BYTE_RST;
        else if (rd_ack_s != rd_ack_d_ff)
            tx_buf_ff <= rd_hold_ff;
    end

    // bit counter and receive shifter, sampled on clock rise
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n || start_det)
        begin
            cnt_ff   <= hwsmb_pkg::CNT_RST;
            shift_ff <= hwsmb_pkg::BYTE_RST;
        end
        else if (scl_fall && (cnt_ff == hwsmb_pkg::BITS_PER_BYTE))
            cnt_ff <= hwsmb_pkg::CNT_RST;
        else if (scl_rise && (state_ff inside {hwsmb_pkg::ST_ADDR, hwsmb_pkg::ST_REG,
                 hwsmb_pkg::ST_DATA, hwsmb_pkg::ST_TX}))
        begin
            cnt_ff   <= cnt_ff + 4'h1;
            shift_ff <= {shift_ff[6:0], sda_s};
        end
    end

    // protocol sequencer; acknowledge and data change only while the clock is low
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            state_ff  <= hwsmb_pkg::ST_IDLE;
            oe_ff     <= 1'b0;
            rw_ff     <= 1'b0;
            ptr_ff    <= hwsmb_pkg::PTR_RST;
            wdat_ff   <= hwsmb_pkg::BYTE_RST;
            tx_ff     <= hwsmb_pkg::BYTE_RST;
            wr_tgl_ff <= 1'b0;
            rd_tgl_ff <= 1'b0;
        end
        else if (stop_det)
        begin
            // a stop after one full data byte commits the write
            if (state_ff == hwsmb_pkg::ST_HOLD)
                wr_tgl_ff <= ~wr_tgl_ff;
            state_ff <= hwsmb_pkg::ST_IDLE;
            oe_ff    <= 1'b0;
        end
        else if (start_det)
        begin
            state_ff <= hwsmb_pkg::ST_ADDR;
            oe_ff    <= 1'b0;
        end
        else if (scl_fall)
        begin
            case (state_ff)
                hwsmb_pkg::ST_ADDR:
                    if (cnt_ff == hwsmb_pkg::BITS_PER_BYTE)
                    begin
                        if (hwsmb_pkg::hwsmb_addr_hit(shift_ff[7:1], strap_ff))
                        begin
                            state_ff <= hwsmb_pkg::ST_ADDR_ACK;
                            oe_ff    <= 1'b1;
                            rw_ff    <= shift_ff[0];
                            if (shift_ff[0])
                                rd_tgl_ff <= ~rd_tgl_ff;
                        end
                        else
                            state_ff <= hwsmb_pkg::ST_IGNORE;
                    end
                hwsmb_pkg::ST_ADDR_ACK:
                    if (rw_ff)
                    begin
                        state_ff <= hwsmb_pkg::ST_TX;
                        tx_ff    <= tx_buf_ff;
                        oe_ff    <= ~tx_buf_ff[7];
                    end
                    else
                    begin
                        state_ff <= hwsmb_pkg::ST_REG;
                        oe_ff    <= 1'b0;
                    end
                hwsmb_pkg::ST_REG:
                    if (cnt_ff == hwsmb_pkg::BITS_PER_BYTE)
                    begin
                        if (hwsmb_pkg::hwsmb_reg_ok(shift_ff))
                        begin
                            state_ff <= hwsmb_pkg::ST_REG_ACK;
                            ptr_ff   <= shift_ff;
                            oe_ff    <= 1'b1;
                        end
                        else
                            state_ff <= hwsmb_pkg::ST_IGNORE;
                    end
                hwsmb_pkg::ST_REG_ACK:
                begin
                    state_ff <= hwsmb_pkg::ST_DATA;
                    oe_ff    <= 1'b0;
                end
                hwsmb_pkg::ST_DATA:
                    if (cnt_ff == hwsmb_pkg::BITS_PER_BYTE)
                    begin
                        state_ff <= hwsmb_pkg::ST_DATA_ACK;
                        wdat_ff  <= shift_ff;
                        oe_ff    <= 1'b1;
                    end
                hwsmb_pkg::ST_DATA_ACK:
                begin
                    state_ff <= hwsmb_pkg::ST_HOLD;
                    oe_ff    <= 1'b0;
                end
                hwsmb_pkg::ST_TX:
                    if (cnt_ff == hwsmb_pkg::BITS_PER_BYTE)
                    begin
                        state_ff <= hwsmb_pkg::ST_TX_ACK;
                        oe_ff    <= 1'b0;
                    end
                    else
                    begin
                        tx_ff <= {tx_ff[6:0], 1'b0};
                        oe_ff <= ~tx_ff[6];
                    end
                hwsmb_pkg::ST_HOLD:
                    // a clock fall here means an extra byte: the write is dropped
                    state_ff <= hwsmb_pkg::ST_IGNORE;
                hwsmb_pkg::ST_TX_ACK:
                    state_ff <= hwsmb_pkg::ST_IGNORE;
                default:
                    oe_ff <= 1'b0;
            endcase
        end
    end

    // open-drain data: only ever pulls low, never touches the clock
    assign sda_o  = 1'b0;
    assign sda_oe = oe_ff;

    // ---------------- reference domain logic ----------------
    // handshake toggles and slow pins brought onto ref_clk
    hwsmb_sync #(.W(4)) u_ref_sync (
        .clk (ref_clk),
        .d   ({wr_tgl_ff, rd_tgl_ff, diode0_neg_or_chain_in, supply12_or_vid_bit4}),
        .q   (rf_sync)
    );
    assign {wr_tgl_s, rd_tgl_s, chain_s, vid_s} = rf_sync;

    // write and read requests turned into one-cycle strobes to the register map
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            wr_tgl_d_ff   <= 1'b0;
            rd_tgl_d_ff   <= 1'b0;
            wr_pulse_ff   <= 1'b0;
            rd_pulse_ff   <= 1'b0;
            wr_ff         <= '0;
            rd_addr_ff    <= hwsmb_pkg::PTR_RST;
        end
        else
        begin
            wr_tgl_d_ff <= wr_tgl_s;
            rd_tgl_d_ff <= rd_tgl_s;
            wr_pulse_ff <= wr_tgl_s ^ wr_tgl_d_ff;
            rd_pulse_ff <= rd_tgl_s ^ rd_tgl_d_ff;
            if (wr_tgl_s ^ wr_tgl_d_ff)
                wr_ff <= '{addr: ptr_ff, data: wdat_ff};
            if (rd_tgl_s ^ rd_tgl_d_ff)
                rd_addr_ff <= ptr_ff;
        end
    end

    // read answer captured and handed back with a toggle
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            rd_hold_ff    <= hwsmb_pkg::BYTE_RST;
            rd_ack_tgl_ff <= 1'b0;
        end
        else if (rd_pulse_ff)
        begin
            rd_hold_ff    <= reg_rd_data;
            rd_ack_tgl_ff <= ~rd_ack_tgl_ff;
        end
    end

    assign reg_wr_pulse = wr_pulse_ff;
    assign reg_wr       = wr_ff;
    assign reg_rd_pulse = rd_pulse_ff;
    assign reg_rd_addr  = rd_addr_ff;

    // reset pulse timer: holds the shared pin low for the full pulse length
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            pulse_cnt_ff <= 32'h0;
        else if (reset_pulse_start && (pin_mode == hwsmb_pkg::PIN_RESET_OUT))
            pulse_cnt_ff <= 32'(RST_PULSE_CYCLES);
        else if (pulse_cnt_ff != 32'h0)
            pulse_cnt_ff <= pulse_cnt_ff - 32'h1;
    end

    // shared pin function select; address-only mode leaves it undriven
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            pin_oe_ff <= 1'b0;
        else
        begin
            case (pin_mode)
                hwsmb_pkg::PIN_RESET_OUT: pin_oe_ff <= (pulse_cnt_ff != 32'h0);
                hwsmb_pkg::PIN_ALERT_OUT: pin_oe_ff <= limit_alert_out;
                hwsmb_pkg::PIN_CHAIN_OUT: pin_oe_ff <= ~chain_s;
                default:                  pin_oe_ff <= 1'b0;
            endcase
        end
    end
    assign shared_addr_alert_pin_o  = 1'b0;
    assign shared_addr_alert_pin_oe = pin_oe_ff;

    // supply input read as a digital id bit only when selected
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            vid_ff <= 1'b0;
        else
            vid_ff <= processor_voltage_id_bit4_select & vid_s;
    end
    assign processor_voltage_id_bit4 = vid_ff;

    // ---------------- checks ----------------
    sequence s_addr_done;
        scl_fall && (state_ff == hwsmb_pkg::ST_ADDR) && (cnt_ff == hwsmb_pkg::BITS_PER_BYTE);
    endsequence

    a_no_general_call: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        s_addr_done and (shift_ff[7:1] == hwsmb_pkg::GEN_CALL_ADDR) |=> !sda_oe)
        else $error("general call was acknowledged");

    a_ack_own_addr: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (s_addr_done and !start_det && !stop_det
         && (shift_ff[7:1] == {hwsmb_pkg::TGT_ADDR_HI, strap_ff})) |=> sda_oe)
        else $error("own address not acknowledged");

    a_write_on_stop: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        $changed(wr_tgl_ff) |-> $past(state_ff == hwsmb_pkg::ST_HOLD) && $past(stop_det))
        else $error("register write without full write byte");

    a_ptr_from_reg: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        $changed(ptr_ff) |-> $past(state_ff == hwsmb_pkg::ST_REG)
                             && (state_ff == hwsmb_pkg::ST_REG_ACK))
        else $error("pointer moved outside the pointer byte");

    a_stop_to_idle: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        stop_det |=> (state_ff == hwsmb_pkg::ST_IDLE) && !sda_oe)
        else $error("stop did not return to idle");

    a_bad_reg_quiet: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (scl_fall && !start_det && !stop_det && (state_ff == hwsmb_pkg::ST_REG)
         && (cnt_ff == hwsmb_pkg::BITS_PER_BYTE) && !hwsmb_pkg::hwsmb_reg_ok(shift_ff))
        |=> (state_ff == hwsmb_pkg::ST_IGNORE) && !sda_oe)
        else $error("invalid register offset answered");

    a_msb_first_out: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (scl_fall && !start_det && !stop_det && (state_ff == hwsmb_pkg::ST_ADDR_ACK) && rw_ff)
        |=> (sda_oe == ~tx_ff[7]) && (tx_ff == $past(tx_buf_ff)))
        else $error("read byte not sent msb first");

    a_one_read_byte: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        (scl_fall && !start_det && !stop_det && (state_ff == hwsmb_pkg::ST_TX_ACK))
        |=> (state_ff == hwsmb_pkg::ST_IGNORE) && !sda_oe)
        else $error("more than one byte offered on read");

    sequence s_pulse_start;
        reset_pulse_start && (pin_mode == hwsmb_pkg::PIN_RESET_OUT);
    endsequence

    a_reset_pulse_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_pulse_start ##1 (!reset_pulse_start && (pin_mode == hwsmb_pkg::PIN_RESET_OUT))
        ##1 (pin_mode == hwsmb_pkg::PIN_RESET_OUT)
        |-> (pulse_cnt_ff == 32'(RST_PULSE_CYCLES) - 32'h1) ##1 shared_addr_alert_pin_oe)
        else $error("reset pulse not driven low");

    a_wr_strobe_data: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_wr_pulse |-> (reg_wr.addr == ptr_ff) && (reg_wr.data == wdat_ff))
        else $error("write strobe carries wrong pointer or data");

endmodule : hwsmb_target

/* hwsmb_target_tb.sv */
/* hwsmb_target_tb: host model on the bus, a byte array serves as the register map.
   assumes pull-ups on sda and on the shared pin, so the strap reads high. */
`timescale 1ns/1ps
module hwsmb_target_tb;
    localparam logic [6:0] ME = 7'h2D;
    logic                       ref_clk, link_clk, reset_n, scl, sda_low, sda_o, sda_oe;
    logic                       pin_o, pin_oe, alert, chain, pstart, vsel, vin, vid, wr_p, rd_p;
    logic [7:0]                 rd_addr, got;
    logic [2:0]                 acks;
    logic [7:0]                 mem[256] = '{default: 8'h00};
    logic [7:0]                 rp[3] = '{8'h20, 8'h7F, 8'h41};
    logic [7:0]                 rv[3] = '{8'h5A, 8'hC3, 8'h3C};
    hwsmb_pkg::hwsmb_wr_t       wr;
    hwsmb_pkg::hwsmb_pin_mode_t mode;
    int                         n_fail = 0, compares = 0, wr_n = 0;
    wire                        sda_w = !(sda_low || sda_oe);
    wire                        pin_w = !pin_oe;

    hwsmb_target #(.RST_PULSE_CYCLES(50)) hwsmb_target_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .link_clk(link_clk), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .shared_addr_alert_pin_i(pin_w),
        .shared_addr_alert_pin_o(pin_o), .shared_addr_alert_pin_oe(pin_oe), .pin_mode(mode),
        .reset_pulse_start(pstart), .limit_alert_out(alert), .diode0_neg_or_chain_in(chain),
        .processor_voltage_id_bit4_select(vsel), .supply12_or_vid_bit4(vin), .processor_voltage_id_bit4(vid),
        .reg_wr_pulse(wr_p), .reg_wr(wr), .reg_rd_pulse(rd_p), .reg_rd_addr(rd_addr),
        .reg_rd_data(mem[rd_addr]));
    hwsmb_host hwsmb_host_inst (.scl(scl), .sda_low(sda_low), .sda(sda_w));

    // reference clock, and a link clock of unrelated phase
    always #10 ref_clk = ~ref_clk;
    initial
    begin
        link_clk = 1'b0;
        #3.7;
        forever #6 link_clk = ~link_clk;
    end
    // register map model: count and apply every write strobe
    always @(posedge ref_clk)
        if (wr_p === 1'b1)
        begin
            mem[wr.addr] <= wr.data;
            wr_n <= wr_n + 1;
        end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %h, wanted %h at %0t ns", g, e, $time);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    // address with write bit, then the pointer byte; no stop
    task automatic ptr(input logic [6:0] a, input logic [7:0] p);
        hwsmb_host_inst.start_c();
        hwsmb_host_inst.wbyte({a, 1'b0}, acks[2]);
        hwsmb_host_inst.wbyte(p, acks[1]);
    endtask : ptr
    task automatic wr3(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
        ptr(a, p);
        hwsmb_host_inst.wbyte(d, acks[0]);
        hwsmb_host_inst.stop_c();
        step(10);
    endtask : wr3
    // address with read bit, one byte back, refused, stop
    task automatic rx;
        hwsmb_host_inst.start_c();
        hwsmb_host_inst.wbyte({ME, 1'b1}, acks[0]);
        hwsmb_host_inst.rbyte(1'b1, got);
        hwsmb_host_inst.stop_c();
    endtask : rx
    task automatic close_out;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // watchdog: the sequence needs well under a millisecond
    initial
    begin
        #1500000;
        n_fail++;
        close_out();
    end
    // main sequence
    initial
    begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        mode = hwsmb_pkg::PIN_ADDR_ONLY;
        {alert, chain, pstart, vsel, vin} = 5'h08;
        step(4);
        chk(wr, 16'h0000);
        chk({rd_addr, sda_oe, pin_oe, wr_p, rd_p}, 12'h000);
        chk({sda_o, pin_o}, 2'b00);
        reset_n = 1'b1;
        step(20);
        // table rows: write byte, then read byte of the same register
        for (int i = 0; i < 3; i++)
        begin
            wr3(ME, rp[i], rv[i]);
            chk({acks, mem[rp[i]]}, {3'b111, rv[i]});
            chk(wr_n, i + 1);
            ptr(ME, rp[i]);
            rx();
            chk({acks, got}, {3'b111, rv[i]});
        end
        // foreign address, general call and dead pointer are refused
        wr3(7'h2C, 8'h20, 8'h11);
        chk(acks, 3'b000);
        wr3(7'h00, 8'h20, 8'h11);
        chk(acks, 3'b000);
        wr3(ME, 8'h80, 8'h11);
        chk(acks, 3'b100);
        chk(wr_n, 3);
        // send byte, then two bare reads of the pointed register
        ptr(ME, 8'h7F);
        hwsmb_host_inst.stop_c();
        rx();
        chk({acks, got}, {3'b111, 8'hC3});
        rx();
        chk({rd_addr, got}, {8'h7F, 8'hC3});
        chk(wr_n, 3);
        // a second data byte is refused and drops the write
        ptr(ME, 8'h20);
        hwsmb_host_inst.wbyte(8'h99, acks[0]);
        hwsmb_host_inst.wbyte(8'h77, got[0]);
        hwsmb_host_inst.stop_c();
        step(10);
        chk({acks, got[0], mem[8'h20]}, {4'b1110, 8'h5A});
        // start then stop, then a normal write still lands
        hwsmb_host_inst.start_c();
        hwsmb_host_inst.stop_c();
        wr3(ME, 8'h30, 8'hE7);
        chk({acks, mem[8'h30]}, {3'b111, 8'hE7});
        // shared pin functions and the id bit input
        mode = hwsmb_pkg::PIN_CHAIN_OUT;
        chain = 1'b0;
        step(6);
        chk(pin_oe, 1'b1);
        chain = 1'b1;
        step(6);
        chk(pin_oe, 1'b0);
        mode = hwsmb_pkg::PIN_ALERT_OUT;
        alert = 1'b1;
        step(3);
        chk(pin_oe, 1'b1);
        mode = hwsmb_pkg::PIN_RESET_OUT;
        alert = 1'b0;
        pstart = 1'b1;
        step(1);
        pstart = 1'b0;
        step(40);
        chk(pin_oe, 1'b1);
        step(20);
        chk(pin_oe, 1'b0);
        {vsel, vin} = 2'b11;
        step(5);
        chk(vid, 1'b1);
        vsel = 1'b0;
        step(5);
        chk(vid, 1'b0);
        close_out();
    end
endmodule : hwsmb_target_tb
